// ### rprr_pkg.sv
// Package with the register map, field layout and carrier types of the RAM power register slice.
package rprr_pkg;

  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int NUM_BANKS = 8;
  localparam int NUM_SECTIONS = 2;
  localparam int SECT_BITS = NUM_BANKS * NUM_SECTIONS;

  // Register offsets (byte addresses).
  localparam logic [11:0] OFS_RETAINED_SCRATCH_TWO = 12'h0520;
  localparam logic [11:0] OFS_BUCK_CONVERTER_ENABLE = 12'h0578;
  localparam logic [11:0] OFS_SECTION_STATUS = 12'h05F0;
  localparam logic [11:0] OFS_BANK_PRESENT = 12'h05F4;
  localparam logic [11:0] OFS_RAM_BANK_POWER = 12'h0900;
  localparam logic [11:0] OFS_RAM_BANK_POWER_SET = 12'h0904;
  localparam logic [11:0] OFS_RAM_BANK_POWER_CLEAR = 12'h0908;
  localparam logic [11:0] OFS_BANK_STRIDE = 12'h0010;

  // Field positions.
  localparam int POS_BUCK_ENABLE = 0;
  localparam int POS_SECT_POWER = 0;
  localparam int POS_SECT_RETAIN = 16;
  localparam int POS_STATUS_POWER = 0;
  localparam int POS_STATUS_KEEP = 16;

  // Reset values.
  localparam logic [31:0] RST_RETAINED_SCRATCH_TWO = 32'h0000_0000;
  localparam logic [31:0] RST_BUCK_CONVERTER_ENABLE = 32'h0000_0000;
  localparam logic [31:0] RST_RAM_BANK_POWER = 32'h0000_FFFF;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } rprr_bus_req_type;

  typedef struct packed {
    logic [NUM_SECTIONS-1:0] retain;
    logic [NUM_SECTIONS-1:0] power;
  } rprr_bank_bits_type;

  typedef enum {
    BANK_OP_NONE,
    BANK_OP_WRITE,
    BANK_OP_SET,
    BANK_OP_CLEAR
  } rprr_bank_op_type;

endpackage : rprr_pkg

// ### rprr_bank_ctrl.sv
// One RAM bank's power control register with its plain, set and clear write views.
`timescale 1ns/1ps
module rprr_bank_ctrl (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_i,
  // Access from the register decoder
  input rprr_pkg::rprr_bank_op_type op_i,
  input wire logic [rprr_pkg::DATA_W-1:0] wdata_i,
  // Stored state
  output rprr_pkg::rprr_bank_bits_type bits_o,
  output logic [rprr_pkg::DATA_W-1:0] word_o
);
  import rprr_pkg::*;

  rprr_bank_bits_type bits_q;
  rprr_bank_bits_type bits_d;
  rprr_bank_bits_type wr_bits;

  always_comb begin
    wr_bits.power = wdata_i[POS_SECT_POWER +: NUM_SECTIONS];
    wr_bits.retain = wdata_i[POS_SECT_RETAIN +: NUM_SECTIONS];
    bits_d = bits_q;
    unique case (op_i)
      BANK_OP_NONE: begin
        bits_d = bits_q;
      end
      BANK_OP_WRITE: begin
        bits_d = wr_bits;
      end
      BANK_OP_SET: begin
        bits_d = bits_q | wr_bits;
      end
      BANK_OP_CLEAR: begin
        bits_d = bits_q & ~wr_bits;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      bits_q.power <= RST_RAM_BANK_POWER[POS_SECT_POWER +: NUM_SECTIONS];
      bits_q.retain <= RST_RAM_BANK_POWER[POS_SECT_RETAIN +: NUM_SECTIONS];
    end else begin
      bits_q <= bits_d;
    end
  end

  // Unused low bits keep reading their reset pattern so a read matches the reset word.
  always_comb begin
    word_o = RST_RAM_BANK_POWER;
    word_o[POS_SECT_POWER +: NUM_SECTIONS] = bits_q.power;
    word_o[POS_SECT_RETAIN +: NUM_SECTIONS] = bits_q.retain;
  end

  assign bits_o = bits_q;

endmodule : rprr_bank_ctrl

// ### rprr_regs.sv
// Register slice for the retained scratch word, the buck converter enable and RAM bank power.
//
// Chosen here: the plain strobed port.
`timescale 1ns/1ps
module rprr_regs #(
  parameter logic [rprr_pkg::NUM_BANKS-1:0] BANK_PRESENT = 8'hFF
) (
  // Clock and resets
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic warm_reset_i,
  // Register port
  input rprr_pkg::rprr_bus_req_type bus_req_i,
  output logic [rprr_pkg::DATA_W-1:0] rdata_o,
  // Power state from the system controller
  input wire logic system_off_i,
  // Power controls
  output logic buck_converter_enable_o,
  output logic [rprr_pkg::SECT_BITS-1:0] ram_section_power_o,
  output logic [rprr_pkg::SECT_BITS-1:0] ram_section_keep_o
);
  import rprr_pkg::*;

  localparam logic [11:0] SET_REL = OFS_RAM_BANK_POWER_SET - OFS_RAM_BANK_POWER;
  localparam logic [11:0] CLR_REL = OFS_RAM_BANK_POWER_CLEAR - OFS_RAM_BANK_POWER;
  localparam logic [11:0] BANK_SPAN = 12'(NUM_BANKS) * OFS_BANK_STRIDE;

  // True when the address lies in the bank window of a present bank.
  function automatic logic bank_hit(input logic [11:0] a);
    logic [11:0] rel;
    logic [11:0] idx;
    rel = a - OFS_RAM_BANK_POWER;
    idx = rel / OFS_BANK_STRIDE;
    bank_hit = 1'b0;
    if (a >= OFS_RAM_BANK_POWER && rel < BANK_SPAN) begin
      bank_hit = BANK_PRESENT[idx[2:0]];
    end
  endfunction : bank_hit

  function automatic logic [2:0] bank_index(input logic [11:0] a);
    logic [11:0] idx;
    idx = (a - OFS_RAM_BANK_POWER) / OFS_BANK_STRIDE;
    bank_index = idx[2:0];
  endfunction : bank_index

  function automatic logic [11:0] bank_rel(input logic [11:0] a);
    bank_rel = (a - OFS_RAM_BANK_POWER) % OFS_BANK_STRIDE;
  endfunction : bank_rel

  logic [31:0] scratch_q;
  logic buck_en_q;
  logic [31:0] rdata_q;
  logic [SECT_BITS-1:0] power_q;
  logic [SECT_BITS-1:0] keep_q;
  logic [SECT_BITS-1:0] power_d;
  logic [SECT_BITS-1:0] keep_d;
  logic bank_reset;
  logic req_bank_hit;
  logic [2:0] req_bank;
  logic [11:0] req_rel;
  logic rel_ok;
  rprr_bank_op_type bank_op [NUM_BANKS];
  rprr_bank_bits_type bank_bits [NUM_BANKS];
  logic [31:0] bank_word [NUM_BANKS];

  // The scratch word only clears on the full reset so warm resets leave it intact.
  assign bank_reset = reset_i | warm_reset_i;

  always_comb begin
    req_bank_hit = bank_hit(bus_req_i.addr);
    req_bank = bank_index(bus_req_i.addr);
    req_rel = bank_rel(bus_req_i.addr);
    rel_ok = (req_rel == 12'h000) || (req_rel == SET_REL) || (req_rel == CLR_REL);
  end

  // Decode writes to the three views of each bank.
  always_comb begin
    for (int b = 0; b < NUM_BANKS; b++) begin
      bank_op[b] = BANK_OP_NONE;
      if (bus_req_i.wr && req_bank_hit && req_bank == 3'(b)) begin
        if (req_rel == 12'h000) begin
          bank_op[b] = BANK_OP_WRITE;
        end else if (req_rel == SET_REL) begin
          bank_op[b] = BANK_OP_SET;
        end else if (req_rel == CLR_REL) begin
          bank_op[b] = BANK_OP_CLEAR;
        end
      end
    end
  end

  for (genvar g = 0; g < NUM_BANKS; g++) begin : g_bank
    if (BANK_PRESENT[g]) begin : g_present
      rprr_bank_ctrl u_bank (
        .clk_sys_i(clk_sys_i),
        .reset_i(bank_reset),
        .op_i(bank_op[g]),
        .wdata_i(bus_req_i.wdata),
        .bits_o(bank_bits[g]),
        .word_o(bank_word[g])
      );
    end else begin : g_absent
      // An absent bank has no storage and never powers its sections.
      assign bank_bits[g] = '0;
      assign bank_word[g] = 32'h0000_0000;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      scratch_q <= RST_RETAINED_SCRATCH_TWO;
    end else if (bus_req_i.wr && bus_req_i.addr == OFS_RETAINED_SCRATCH_TWO) begin
      scratch_q <= bus_req_i.wdata;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (bank_reset) begin
      buck_en_q <= RST_BUCK_CONVERTER_ENABLE[POS_BUCK_ENABLE];
    end else if (bus_req_i.wr && bus_req_i.addr == OFS_BUCK_CONVERTER_ENABLE) begin
      buck_en_q <= bus_req_i.wdata[POS_BUCK_ENABLE];
    end
  end

  // Effective section controls; System OFF overrides every power bit.
  always_comb begin
    for (int b = 0; b < NUM_BANKS; b++) begin
      for (int s = 0; s < NUM_SECTIONS; s++) begin
        power_d[b*NUM_SECTIONS+s] = bank_bits[b].power[s] & ~system_off_i;
        keep_d[b*NUM_SECTIONS+s] = power_d[b*NUM_SECTIONS+s]
                                   | bank_bits[b].retain[s];
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (bank_reset) begin
      power_q <= '0;
      keep_q <= '0;
    end else begin
      power_q <= power_d;
      keep_q <= keep_d;
    end
  end

  // Read data stand only in the cycle after the strobe; otherwise the port reads zero.
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      rdata_q <= 32'h0000_0000;
    end else if (!bus_req_i.rd) begin
      rdata_q <= 32'h0000_0000;
    end else if (req_bank_hit && rel_ok) begin
      rdata_q <= bank_word[req_bank];
    end else begin
      unique case (bus_req_i.addr)
        OFS_RETAINED_SCRATCH_TWO: begin
          rdata_q <= scratch_q;
        end
        OFS_BUCK_CONVERTER_ENABLE: begin
          rdata_q <= 32'(buck_en_q) << POS_BUCK_ENABLE;
        end
        OFS_SECTION_STATUS: begin
          rdata_q <= (32'(power_q) << POS_STATUS_POWER) | (32'(keep_q) << POS_STATUS_KEEP);
        end
        OFS_BANK_PRESENT: begin
          rdata_q <= 32'(BANK_PRESENT);
        end
        default: begin
          rdata_q <= 32'h0000_0000;
        end
      endcase
    end
  end

  assign rdata_o = rdata_q;
  assign buck_converter_enable_o = buck_en_q;
  assign ram_section_power_o = power_q;
  assign ram_section_keep_o = keep_q;

endmodule : rprr_regs

// ### rprr_regs_sva.sv
// Checker for the ports of the RAM power register slice.
`timescale 1ns/1ps
module rprr_regs_sva #(parameter logic [7:0] BANK_PRESENT = 8'hFF) (
  // Clock and resets
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic warm_reset_i,
  // Register port
  input rprr_pkg::rprr_bus_req_type bus_req_i,
  input wire logic [31:0] rdata_o,
  // Power state and controls
  input wire logic system_off_i,
  input wire logic buck_converter_enable_o,
  input wire logic [15:0] ram_section_power_o,
  input wire logic [15:0] ram_section_keep_o
);
  import rprr_pkg::*;
  logic [11:0] a;
  logic bank;
  logic w_buck;
  assign a = bus_req_i.addr;
  assign bank = a[11:7] == 5'h12 && BANK_PRESENT[a[6:4]];
  assign w_buck = bus_req_i.wr && a == OFS_BUCK_CONVERTER_ENABLE;
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);
  sequence s_scr_wr; bus_req_i.wr && a == OFS_RETAINED_SCRATCH_TWO; endsequence
  sequence s_scr_rd; bus_req_i.rd && a == OFS_RETAINED_SCRATCH_TWO; endsequence
  property p_rd_idle; !$past(bus_req_i.rd) |-> rdata_o == 32'h0000_0000; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside read cycle");
  property p_scr; s_scr_wr ##1 s_scr_rd |=> rdata_o == $past(bus_req_i.wdata, 2); endproperty
  a_scr: assert property (p_scr) else $error("scratch readback wrong");
  property p_buck;
    $changed(buck_converter_enable_o) |-> $past(w_buck) || $past(w_buck, 2)
      || $past(warm_reset_i) || $past(warm_reset_i, 2);
  endproperty
  a_buck: assert property (p_buck) else $error("converter enable changed unasked");
  property p_off; system_off_i [*2] |-> ram_section_power_o == 16'h0000; endproperty
  a_off: assert property (p_off) else $error("section powered in off state");
  property p_keep; (ram_section_power_o & ~ram_section_keep_o) == 16'h0000; endproperty
  a_keep: assert property (p_keep) else $error("powered section not kept");
  property p_absent;
    bus_req_i.rd && a[11:7] == 5'h12 && !BANK_PRESENT[a[6:4]] |=> rdata_o == 32'h0000_0000;
  endproperty
  a_absent: assert property (p_absent) else $error("absent bank read nonzero");
  property p_fixed;
    bus_req_i.rd && bank && a[3:0] <= 4'h8 && a[1:0] == 2'h0
      |=> rdata_o[31:18] == 14'h0000 && rdata_o[15:2] == 14'h3FFF;
  endproperty
  a_fixed: assert property (p_fixed) else $error("bank word fixed bits wrong");
  property p_set;
    bus_req_i.wr && bank && a[3:0] == 4'h4 && bus_req_i.wdata[1] && !system_off_i
      && !warm_reset_i |=> !system_off_i && !warm_reset_i
      |=> ram_section_power_o[2 * $past(a[6:4], 2) + 1];
  endproperty
  a_set: assert property (p_set) else $error("set alias did not power section");
  property p_clr;
    bus_req_i.wr && bank && a[3:0] == 4'h8 && bus_req_i.wdata[0]
      |=> ##1 !ram_section_power_o[2 * $past(a[6:4], 2)];
  endproperty
  a_clr: assert property (p_clr) else $error("clear alias left section powered");
endmodule : rprr_regs_sva

bind rprr_regs rprr_regs_sva #(.BANK_PRESENT(BANK_PRESENT)) i_sva (
  .clk_sys_i(clk_sys_i), .reset_i(reset_i), .warm_reset_i(warm_reset_i),
  .bus_req_i(bus_req_i), .rdata_o(rdata_o), .system_off_i(system_off_i),
  .buck_converter_enable_o(buck_converter_enable_o),
  .ram_section_power_o(ram_section_power_o), .ram_section_keep_o(ram_section_keep_o));

// ### rprr_regs_tb_top.sv
// Self-checking bench for the RAM power register slice.
`timescale 1ns/1ps
module rprr_regs_tb_top;
  import rprr_pkg::*;
  logic clk_sys_i = 1'b0;
  logic reset_i = 1'b1;
  logic warm_reset_i = 1'b0;
  logic system_off_i = 1'b0;
  rprr_bus_req_type req = '0;
  logic [31:0] rdata;
  logic buck;
  logic [15:0] pwr;
  logic [15:0] keep;
  int num_errors = 0;
  int checks = 0;
  // Rows: write flag, address, then write data or expected read data.
  logic [44:0] rows [19] = '{
    {1'b0, 12'h0520, 32'h0000_0000}, {1'b0, 12'h0578, 32'h0000_0000},
    {1'b0, 12'h0900, 32'h0000_FFFF}, {1'b0, 12'h0970, 32'h0000_0000},
    {1'b1, 12'h0520, 32'hA5A5_5A5A}, {1'b0, 12'h0520, 32'hA5A5_5A5A},
    {1'b1, 12'h0578, 32'h0000_0001}, {1'b0, 12'h0578, 32'h0000_0001},
    {1'b1, 12'h0918, 32'h0000_0003}, {1'b0, 12'h0910, 32'h0000_FFFC},
    {1'b1, 12'h0914, 32'h0003_0002}, {1'b0, 12'h0914, 32'h0003_FFFE},
    {1'b0, 12'h0918, 32'h0003_FFFE}, {1'b1, 12'h0970, 32'hFFFF_FFFF},
    {1'b0, 12'h0970, 32'h0000_0000}, {1'b1, 12'h0960, 32'h0000_0000},
    {1'b0, 12'h0968, 32'h0000_FFFC}, {1'b1, 12'h0004, 32'hFFFF_FFFF},
    {1'b0, 12'h0004, 32'h0000_0000}};

  rprr_regs #(.BANK_PRESENT(8'h7F)) i_dut (
    .clk_sys_i(clk_sys_i), .reset_i(reset_i), .warm_reset_i(warm_reset_i),
    .bus_req_i(req), .rdata_o(rdata), .system_off_i(system_off_i),
    .buck_converter_enable_o(buck), .ram_section_power_o(pwr), .ram_section_keep_o(keep));

  always #4 clk_sys_i = ~clk_sys_i;

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      $display("unexpected %s expected %h seen %h", n, e, g);
      num_errors++;
    end
  endtask : chk

  // One bus cycle; the strobe drops at the next edge, so back-to-back calls never collide.
  task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    req <= '{addr: a, wdata: w ? d : 32'h0000_0000, wr: w, rd: !w};
    @(posedge clk_sys_i);
    req <= '0;
    #1;
    if (!w) chk($sformatf("read %h", a), d, rdata);
  endtask : acc

  task automatic pulse_reset(input logic warm);
    @(posedge clk_sys_i);
    if (warm) warm_reset_i <= 1'b1;
    else reset_i <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    warm_reset_i <= 1'b0;
    reset_i <= 1'b0;
  endtask : pulse_reset

  task automatic summarize;
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : summarize

  initial begin
    repeat (10) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    foreach (rows[i]) acc(rows[i][44], rows[i][43:32], rows[i][31:0]);
    $display("test register rows done");
    repeat (2) @(posedge clk_sys_i);
    #1;
    chk("power", 32'h0000_0FFB, {16'h0000, pwr});
    chk("keep", 32'h0000_0FFF, {16'h0000, keep});
    chk("buck", 32'h0000_0001, {31'h0000_0000, buck});
    acc(1'b0, OFS_SECTION_STATUS, 32'h0FFF_0FFB);
    acc(1'b0, OFS_BANK_PRESENT, 32'h0000_007F);
    @(posedge clk_sys_i);
    system_off_i <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
    #1;
    chk("off power", 32'h0000_0000, {16'h0000, pwr});
    chk("off keep", 32'h0000_000C, {16'h0000, keep});
    acc(1'b0, OFS_SECTION_STATUS, 32'h000C_0000);
    @(posedge clk_sys_i);
    system_off_i <= 1'b0;
    $display("test outputs done");
    pulse_reset(1'b1);
    acc(1'b0, 12'h0520, 32'hA5A5_5A5A);
    acc(1'b0, 12'h0578, 32'h0000_0000);
    acc(1'b0, 12'h0910, 32'h0000_FFFF);
    $display("test warm reset done");
    pulse_reset(1'b0);
    acc(1'b0, 12'h0520, 32'h0000_0000);
    $display("test full reset done");
    // A write and a read of the scratch word with no idle cycle between the strobes.
    @(posedge clk_sys_i);
    req <= '{addr: OFS_RETAINED_SCRATCH_TWO, wdata: 32'h1234_5678, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys_i);
    req <= '{addr: OFS_RETAINED_SCRATCH_TWO, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys_i);
    req <= '0;
    #1;
    chk("scratch back to back", 32'h1234_5678, rdata);
    $display("test back to back done");
    summarize();
  end
endmodule : rprr_regs_tb_top
